// ---- core/led_cmd_pkg.sv ----
// Constants and types for the serial command decoder of the LED sink driver.
// Assumes one system clock mclk; link pins arrive asynchronous to it.
// Operation
// - Strobe-high edge count selects command; 2,3,14 special
// - Count one latches shift register into buffers
// - Counts 4,6,8,10 write config registers one-four
// - Counts 5,7,9,11 select config register read-back
// - Count twelve enables all sixteen outputs
// - Count thirteen disables all sixteen outputs
// - Shift clock shifts data and times commands
// - Sixteen-bit shift register collects serial input
package led_cmd_pkg;
  localparam int WORD_W = 16;
  localparam int CHANNELS = 16;
  localparam int CNT_W = 5;
  localparam logic [4:0] CNT_LATCH = 5'h01;
  localparam logic [4:0] CNT_DBG = 5'h02;
  localparam logic [4:0] CNT_FRAME_SYNC = 5'h03;
  localparam logic [4:0] CNT_CFG1_WRITE = 5'h04;
  localparam logic [4:0] CNT_CFG1_READ = 5'h05;
  localparam logic [4:0] CNT_CFG2_WRITE = 5'h06;
  localparam logic [4:0] CNT_CFG2_READ = 5'h07;
  localparam logic [4:0] CNT_CFG3_WRITE = 5'h08;
  localparam logic [4:0] CNT_CFG3_READ = 5'h09;
  localparam logic [4:0] CNT_CFG4_WRITE = 5'h0a;
  localparam logic [4:0] CNT_CFG4_READ = 5'h0b;
  localparam logic [4:0] CNT_OUT_ON = 5'h0c;
  localparam logic [4:0] CNT_OUT_OFF = 5'h0d;
  localparam logic [4:0] CNT_PREACTIVATE = 5'h0e;
  localparam logic [4:0] CNT_MAX = 5'h1f;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0] SEL_RESET = 2'h0;

  typedef struct packed {
    logic shiftClock;
    logic commandStrobe;
    logic serialIn;
  } link_in_t;

  typedef struct packed {
    logic [15:0] word;
    logic valid;
  } word_out_t;

  typedef struct packed {
    logic [2:0] clkSync1;
    logic [2:0] clkSync2;
    logic clkPrev;
    logic strobePrev;
    logic [4:0] edgeCount;
    logic [15:0] shiftReg;
    word_out_t latchOut;
    word_out_t debugOut;
    word_out_t cfg1Out;
    word_out_t cfg2Out;
    word_out_t cfg3Out;
    word_out_t cfg4Out;
    logic frameSync;
    logic preActivate;
    logic readValid;
    logic [1:0] readSel;
    logic [15:0] outputsOn;
  } dec_state_t;
endpackage

// ---- core/led_driver_serial_command_decoder.sv ----
// Serial command decoder: shifts data and decodes strobe-high edge counts.
// Assumes shift clock far slower than mclk (needs at least 3 mclk per half period).
`timescale 1ns/10ps
module led_driver_serial_command_decoder (
  input wire logic mclk,
  input wire logic resetn,
  input wire led_cmd_pkg::link_in_t linkIn,
  output led_cmd_pkg::word_out_t latchOut,
  output led_cmd_pkg::word_out_t debugOut,
  output led_cmd_pkg::word_out_t cfg1Out,
  output led_cmd_pkg::word_out_t cfg2Out,
  output led_cmd_pkg::word_out_t cfg3Out,
  output led_cmd_pkg::word_out_t cfg4Out,
  output logic frameSync,
  output logic preActivate,
  output logic readValid,
  output logic [1:0] readSel,
  output logic [15:0] outputsOn
);
  led_cmd_pkg::dec_state_t state_r;
  led_cmd_pkg::dec_state_t state_nxt;
  // Sync stages clear to the idle low pin level, so no false edge follows reset
  localparam led_cmd_pkg::dec_state_t STATE_RESET = '{
    clkSync1: 3'h0,
    clkSync2: 3'h0,
    clkPrev: 1'b0,
    strobePrev: 1'b0,
    edgeCount: 5'h00,
    shiftReg: led_cmd_pkg::WORD_RESET,
    latchOut: '{word: led_cmd_pkg::WORD_RESET, valid: 1'b0},
    debugOut: '{word: led_cmd_pkg::WORD_RESET, valid: 1'b0},
    cfg1Out: '{word: led_cmd_pkg::WORD_RESET, valid: 1'b0},
    cfg2Out: '{word: led_cmd_pkg::WORD_RESET, valid: 1'b0},
    cfg3Out: '{word: led_cmd_pkg::WORD_RESET, valid: 1'b0},
    cfg4Out: '{word: led_cmd_pkg::WORD_RESET, valid: 1'b0},
    frameSync: 1'b0,
    preActivate: 1'b0,
    readValid: 1'b0,
    readSel: led_cmd_pkg::SEL_RESET,
    outputsOn: 16'h0000
  };
  logic clkS;
  logic strobeS;
  logic dataS;
  logic clkRise;
  logic strobeFall;

  // All three pins synchronised together; first stage read only by second
  assign clkS = state_r.clkSync2[2];
  assign strobeS = state_r.clkSync2[1];
  assign dataS = state_r.clkSync2[0];
  assign clkRise = clkS && !state_r.clkPrev;
  assign strobeFall = !strobeS && state_r.strobePrev;

  always_comb begin
    state_nxt = state_r;
    state_nxt.clkSync1 = {linkIn.shiftClock, linkIn.commandStrobe, linkIn.serialIn};
    state_nxt.clkSync2 = state_r.clkSync1;
    state_nxt.clkPrev = clkS;
    state_nxt.strobePrev = strobeS;
    state_nxt.latchOut.valid = 1'b0;
    state_nxt.debugOut.valid = 1'b0;
    state_nxt.cfg1Out.valid = 1'b0;
    state_nxt.cfg2Out.valid = 1'b0;
    state_nxt.cfg3Out.valid = 1'b0;
    state_nxt.cfg4Out.valid = 1'b0;
    state_nxt.frameSync = 1'b0;
    state_nxt.preActivate = 1'b0;
    state_nxt.readValid = 1'b0;
    if (clkRise) begin
      state_nxt.shiftReg = {state_r.shiftReg[14:0], dataS};
      // Saturate so an overlong strobe never wraps into a valid count
      if (strobeS && state_r.edgeCount != led_cmd_pkg::CNT_MAX) begin
        state_nxt.edgeCount = state_r.edgeCount + 5'h01;
      end
    end
    // Decode only once the strobe is low, when the count can no longer grow
    if (strobeFall) begin
      state_nxt.edgeCount = 5'h00;
      case (state_r.edgeCount)
        led_cmd_pkg::CNT_LATCH: begin
          state_nxt.latchOut = '{word: state_r.shiftReg, valid: 1'b1};
        end
        led_cmd_pkg::CNT_DBG: begin
          state_nxt.debugOut = '{word: state_r.shiftReg, valid: 1'b1};
        end
        led_cmd_pkg::CNT_FRAME_SYNC: begin
          state_nxt.frameSync = 1'b1;
        end
        led_cmd_pkg::CNT_CFG1_WRITE: begin
          state_nxt.cfg1Out = '{word: state_r.shiftReg, valid: 1'b1};
        end
        led_cmd_pkg::CNT_CFG2_WRITE: begin
          state_nxt.cfg2Out = '{word: state_r.shiftReg, valid: 1'b1};
        end
        led_cmd_pkg::CNT_CFG3_WRITE: begin
          state_nxt.cfg3Out = '{word: state_r.shiftReg, valid: 1'b1};
        end
        led_cmd_pkg::CNT_CFG4_WRITE: begin
          state_nxt.cfg4Out = '{word: state_r.shiftReg, valid: 1'b1};
        end
        // Read-back only selects; readSel holds until the next read
        led_cmd_pkg::CNT_CFG1_READ: begin
          state_nxt.readValid = 1'b1;
          state_nxt.readSel = 2'h0;
        end
        led_cmd_pkg::CNT_CFG2_READ: begin
          state_nxt.readValid = 1'b1;
          state_nxt.readSel = 2'h1;
        end
        led_cmd_pkg::CNT_CFG3_READ: begin
          state_nxt.readValid = 1'b1;
          state_nxt.readSel = 2'h2;
        end
        led_cmd_pkg::CNT_CFG4_READ: begin
          state_nxt.readValid = 1'b1;
          state_nxt.readSel = 2'h3;
        end
        led_cmd_pkg::CNT_OUT_ON: begin
          state_nxt.outputsOn = {led_cmd_pkg::CHANNELS{1'b1}};
        end
        led_cmd_pkg::CNT_OUT_OFF: begin
          state_nxt.outputsOn = {led_cmd_pkg::CHANNELS{1'b0}};
        end
        led_cmd_pkg::CNT_PREACTIVATE: begin
          state_nxt.preActivate = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_r <= STATE_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign latchOut = state_r.latchOut;
  assign debugOut = state_r.debugOut;
  assign cfg1Out = state_r.cfg1Out;
  assign cfg2Out = state_r.cfg2Out;
  assign cfg3Out = state_r.cfg3Out;
  assign cfg4Out = state_r.cfg4Out;
  assign frameSync = state_r.frameSync;
  assign preActivate = state_r.preActivate;
  assign readValid = state_r.readValid;
  assign readSel = state_r.readSel;
  assign outputsOn = state_r.outputsOn;
endmodule

// ---- verification/led_cmd_checker.sv ----
// Checker for the command decoder outputs.
// Sees only the decoder ports; bound at the foot of the file.
`timescale 1ns/10ps
module led_cmd_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire led_cmd_pkg::link_in_t linkIn,
  input wire led_cmd_pkg::word_out_t latchOut,
  input wire led_cmd_pkg::word_out_t debugOut,
  input wire led_cmd_pkg::word_out_t cfg1Out,
  input wire led_cmd_pkg::word_out_t cfg2Out,
  input wire led_cmd_pkg::word_out_t cfg3Out,
  input wire led_cmd_pkg::word_out_t cfg4Out,
  input wire logic frameSync,
  input wire logic preActivate,
  input wire logic readValid,
  input wire logic [1:0] readSel,
  input wire logic [15:0] outputsOn
);
  wire [8:0] pv = {preActivate, readValid, cfg4Out.valid, cfg3Out.valid, cfg2Out.valid,
    cfg1Out.valid, frameSync, debugOut.valid, latchOut.valid};
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Pin strobe already low two edges back
  sequence s_fell;
    !$past(linkIn.commandStrobe, 2);
  endsequence
  a_one_cmd: assert property ($onehot0(pv)) else $error("two commands at once");
  a_pulse_one: assert property (|pv |=> !(|pv)) else $error("pulse too long");
  a_act_fall: assert property (|pv |-> s_fell) else $error("command while strobe high");
  a_latch_hold: assert property (!latchOut.valid |-> $stable(latchOut.word))
    else $error("buffer word moved");
  a_cfg_hold: assert property (!cfg1Out.valid |-> $stable(cfg1Out.word))
    else $error("config word moved");
  a_sel_hold: assert property (!readValid |-> $stable(readSel)) else $error("read select moved");
  a_outs_all: assert property ($changed(outputsOn) |-> outputsOn inside {16'hffff, 16'h0000})
    else $error("outputs not switched together");
  a_outs_cause: assert property ($changed(outputsOn) |-> s_fell)
    else $error("outputs changed while strobe high");
endmodule
bind led_driver_serial_command_decoder led_cmd_checker i_led_cmd_checker (
  .mclk(mclk),
  .resetn(resetn),
  .linkIn(linkIn),
  .latchOut(latchOut),
  .debugOut(debugOut),
  .cfg1Out(cfg1Out),
  .cfg2Out(cfg2Out),
  .cfg3Out(cfg3Out),
  .cfg4Out(cfg4Out),
  .frameSync(frameSync),
  .preActivate(preActivate),
  .readValid(readValid),
  .readSel(readSel),
  .outputsOn(outputsOn)
);

// ---- verification/led_ctrl_model.sv ----
// Display controller model: shift clock, strobe and serial data.
// Shift clock idles low between frames; 48 ns period, edges always on mclk falling edges.
`timescale 1ns/10ps
module led_ctrl_model (
  output led_cmd_pkg::link_in_t linkIn
);
  initial linkIn = '0;
  // Last n rises carry the strobe; word goes out MSB first
  task automatic cmd(input int n, input logic [15:0] w);
    int t;
    t = (n > 16) ? n : 16;
    // Leading bits of a long frame are zero; the word fills the last 16 rises
    for (int i = 0; i < t; i++) begin
      #12 linkIn.serialIn = (i >= t - 16) ? w[t - 1 - i] : 1'b0;
      linkIn.commandStrobe = (i >= t - n);
      #12 linkIn.shiftClock = 1'b1;
      #24 linkIn.shiftClock = 1'b0;
    end
    #12 linkIn.commandStrobe = 1'b0;
  endtask
endmodule

// ---- verification/tb_led_driver_serial_command_decoder.sv ----
// Self-checking bench for the serial command decoder.
// Commands come from the controller model; counts partly random, words random.
`timescale 1ns/10ps
module tb_led_driver_serial_command_decoder;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  led_cmd_pkg::link_in_t linkIn;
  led_cmd_pkg::word_out_t latchOut, debugOut, cfg1Out, cfg2Out, cfg3Out, cfg4Out;
  logic frameSync, preActivate, readValid;
  logic [1:0] readSel;
  logic [15:0] outputsOn;
  int n_errors = 0;
  int checked = 0;
  initial forever #2 mclk = ~mclk;
  led_ctrl_model i_led_ctrl_model (
    .linkIn(linkIn)
  );
  led_driver_serial_command_decoder i_led_driver_serial_command_decoder (
    .mclk(mclk),
    .resetn(resetn),
    .linkIn(linkIn),
    .latchOut(latchOut),
    .debugOut(debugOut),
    .cfg1Out(cfg1Out),
    .cfg2Out(cfg2Out),
    .cfg3Out(cfg3Out),
    .cfg4Out(cfg4Out),
    .frameSync(frameSync),
    .preActivate(preActivate),
    .readValid(readValid),
    .readSel(readSel),
    .outputsOn(outputsOn)
  );
  wire [8:0] pv = {preActivate, readValid, cfg4Out.valid, cfg3Out.valid, cfg2Out.valid,
    cfg1Out.valid, frameSync, debugOut.valid, latchOut.valid};
  wire [6:0][15:0] wv = {cfg4Out.word, cfg3Out.word, cfg2Out.word, cfg1Out.word, 16'h0000,
    debugOut.word, latchOut.word};
  // Pulse slot per count; 9 means no pulse
  function automatic int slot(input int n);
    case (n)
      1, 2, 3: return n - 1;
      4, 6, 8, 10: return n / 2 + 1;
      5, 7, 9, 11: return 7;
      14: return 8;
      default: return 9;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input int n);
    logic [15:0] w;
    logic [8:0] seen;
    int s;
    w = 16'($urandom);
    s = slot(n);
    seen = '0;
    i_led_ctrl_model.cmd(n, w);
    repeat (10) @(negedge mclk) seen |= pv;
    chk({7'h00, seen}, (s < 9) ? 16'h0001 << s : 16'h0000);
    if (s < 7 && s != 2) chk(wv[s], w);
    if (s == 7) chk({14'h0000, readSel}, 16'((n - 5) / 2));
    if (n == 12 || n == 13) chk(outputsOn, {16{n == 12}});
  endtask
  task automatic stop_test();
    $display("Errors %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(38));
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    for (int n = 0; n < 18; n++) run(n);
    // Count far past the counter width: a wrapping counter would hit a write
    run(40);
    run(12);
    // Mid-run reset with outputs on; decoding must resume afterwards
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    chk(outputsOn, 16'h0000);
    repeat (20) run($urandom_range(1, 14));
    stop_test();
  end
endmodule
